// ### verilog/sd_monitor_pkg.sv
// shared constants and carriers for the comparator filter and clock monitor
package sd_monitor_pkg;

	localparam int unsigned CLK_FREQ_HZ    = 10_000_000;
	localparam int unsigned WORD_BITS      = 8;
	localparam int unsigned FIFO_DEPTH     = 32;
	localparam int unsigned ACC_WIDTH      = 32;
	localparam int unsigned OSR_WIDTH      = 5;
	localparam int unsigned CLKFAIL_CYCLES = 256;
	localparam int unsigned FAILCNT_WIDTH  = 8;

	localparam logic [FAILCNT_WIDTH-1:0] FAILCNT_LAST  = 8'hFF;
	localparam logic [FAILCNT_WIDTH-1:0] FAILCNT_RESET = 8'h00;
	localparam logic [2:0]               BITCNT_LAST   = 3'h7;
	localparam logic [2:0]               BITCNT_RESET  = 3'h0;
	localparam logic [ACC_WIDTH-1:0]     ACC_RESET     = 32'h0000_0000;
	localparam logic [OSR_WIDTH-1:0]     OSR_RESET     = 5'h00;
	localparam logic [WORD_BITS-1:0]     WORD_RESET    = 8'h00;

	typedef enum logic [1:0] {
		SINC_DEFAULT,
		SINC_ORDER1,
		SINC_ORDER2,
		SINC_ORDER3
	} sincOrder_t;

	typedef struct packed {
		logic                 enable;
		sincOrder_t           order;
		logic [OSR_WIDTH-1:0] osrWords;
		logic [ACC_WIDTH-1:0] highLimit;
		logic [ACC_WIDTH-1:0] lowLimit;
	} compCfg_t;

	typedef struct packed {
		logic overValue;
		logic underValue;
		logic clockFail;
		logic overrun;
	} monStatus_t;

	typedef struct packed {
		logic                 valid;
		logic [ACC_WIDTH-1:0] data;
	} compSample_t;

endpackage

// ### verilog/bit_word_fifo.sv
// single clock flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
module bit_word_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [AW-1:0]    wrPtr_reg, wrPtr_next;
	logic [AW-1:0]    rdPtr_reg, rdPtr_next;
	logic [AW:0]      count_reg, count_next;
	logic             push;
	logic             pop;

	assign inReady  = (count_reg != (AW + 1)'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData  = mem_reg[rdPtr_reg];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always_comb begin
		mem_next   = mem_reg;
		wrPtr_next = wrPtr_reg;
		rdPtr_next = rdPtr_reg;
		count_next = count_reg;
		if (push) begin
			mem_next[wrPtr_reg] = inData;
			wrPtr_next = (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
		end
		if (pop) begin
			rdPtr_next = (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
		end
		unique case ({push, pop})
			2'b10:   count_next = count_reg + 1'b1;
			2'b01:   count_next = count_reg - 1'b1;
			default: count_next = count_reg;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
		end else begin
			wrPtr_reg <= wrPtr_next;
			rdPtr_reg <= rdPtr_next;
			count_reg <= count_next;
			mem_reg   <= mem_next;
		end
	end

endmodule

// ### verilog/sigma_delta_filter_unit.sv
// comparator sinc filter with limit checks and modulator clock fail monitor
// Notes on behaviour
// - comparator path has its own software-configured sinc filter on the modulator bitstream
// - each filter output is checked against a high and a low limit
// - crossing either limit raises an interrupt request to the processor
// - no modulator clock activity for 256 system clocks flags failure and interrupts
// - high limit at minimum and low at maximum fires on every sample
`timescale 1ns/1ns
module sigma_delta_filter_unit (
	input  wire logic                        clk,
	input  wire logic                        nrst,
	input  wire logic                        modClk,
	input  wire logic                        modData,
	input  wire sd_monitor_pkg::compCfg_t    cfg,
	input  wire logic                        overClr,
	input  wire logic                        underClr,
	input  wire logic                        clockFailClr,
	input  wire logic                        overrunClr,
	output sd_monitor_pkg::compSample_t      sample,
	output sd_monitor_pkg::monStatus_t       status,
	output logic                             compIrq,
	output logic                             clockFailIrq
);
	localparam int unsigned W = sd_monitor_pkg::ACC_WIDTH;
	localparam int unsigned B = sd_monitor_pkg::WORD_BITS;

	////////////////////////////////////////////////////////////////////////////////
	// link domain: pack bitstream into words, flag each word by a toggle

	logic [B-1:0] shift_reg, shift_next;
	logic [2:0]   bitCnt_reg, bitCnt_next;
	logic [B-1:0] word_reg, word_next;
	logic         wordTog_reg, wordTog_next;
	logic         edgeTog_reg, edgeTog_next;

	always_comb begin
		shift_next   = {shift_reg[B-2:0], modData};
		bitCnt_next  = bitCnt_reg + 1'b1;
		word_next    = word_reg;
		wordTog_next = wordTog_reg;
		edgeTog_next = ~edgeTog_reg;
		if (bitCnt_reg == sd_monitor_pkg::BITCNT_LAST) begin
			word_next    = {shift_reg[B-2:0], modData};
			wordTog_next = ~wordTog_reg;
		end
	end

	// word_reg is held for eight modulator clocks, far longer than the crossing needs
	always_ff @(posedge modClk or negedge nrst) begin
		if (!nrst) begin
			shift_reg   <= sd_monitor_pkg::WORD_RESET;
			bitCnt_reg  <= sd_monitor_pkg::BITCNT_RESET;
			word_reg    <= sd_monitor_pkg::WORD_RESET;
			wordTog_reg <= 1'b0;
			edgeTog_reg <= 1'b0;
		end else begin
			shift_reg   <= shift_next;
			bitCnt_reg  <= bitCnt_next;
			word_reg    <= word_next;
			wordTog_reg <= wordTog_next;
			edgeTog_reg <= edgeTog_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// crossing into the system clock

	logic [2:0] wordSync_reg, wordSync_next;
	logic [2:0] edgeSync_reg, edgeSync_next;
	logic       wordArrive;
	logic       modEdge;

	always_comb begin
		wordSync_next = {wordSync_reg[1:0], wordTog_reg};
		edgeSync_next = {edgeSync_reg[1:0], edgeTog_reg};
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wordSync_reg <= 3'h0;
			edgeSync_reg <= 3'h0;
		end else begin
			wordSync_reg <= wordSync_next;
			edgeSync_reg <= edgeSync_next;
		end
	end

	// only stages 1 and 2 are compared; stage 0 feeds stage 1 alone
	assign wordArrive = wordSync_reg[2] ^ wordSync_reg[1];
	assign modEdge    = edgeSync_reg[2] ^ edgeSync_reg[1];

	////////////////////////////////////////////////////////////////////////////////
	// word fifo; the filter drains only while enabled

	logic         fifoInReady;
	logic         fifoOutValid;
	logic [B-1:0] fifoOutData;
	logic         fifoPop;

	assign fifoPop = fifoOutValid && cfg.enable;

	bit_word_fifo #(
		.WIDTH (B),
		.DEPTH (sd_monitor_pkg::FIFO_DEPTH)
	) wordFifo (
		.clk      (clk),
		.nrst     (nrst),
		.inValid  (wordArrive),
		.inReady  (fifoInReady),
		.inData   (word_reg),
		.outValid (fifoOutValid),
		.outReady (cfg.enable),
		.outData  (fifoOutData)
	);

	////////////////////////////////////////////////////////////////////////////////
	// sinc filter: three integrators per bit, combs at the decimation point

	logic [W-1:0]                          int1_reg, int1_next;
	logic [W-1:0]                          int2_reg, int2_next;
	logic [W-1:0]                          int3_reg, int3_next;
	logic [W-1:0]                          comb1_reg, comb1_next;
	logic [W-1:0]                          comb2_reg, comb2_next;
	logic [W-1:0]                          comb3_reg, comb3_next;
	logic [sd_monitor_pkg::OSR_WIDTH-1:0]  decCnt_reg, decCnt_next;
	sd_monitor_pkg::compSample_t           sample_reg, sample_next;

	always_comb begin
		logic [W-1:0] x;
		logic [W-1:0] c1;
		logic [W-1:0] c2;
		logic [W-1:0] c3;
		x           = '0;
		c1          = '0;
		c2          = '0;
		c3          = '0;
		int1_next   = int1_reg;
		int2_next   = int2_reg;
		int3_next   = int3_reg;
		comb1_next  = comb1_reg;
		comb2_next  = comb2_reg;
		comb3_next  = comb3_reg;
		decCnt_next = decCnt_reg;
		sample_next = '{valid: 1'b0, data: sample_reg.data};
		if (fifoPop) begin
			// oldest bit sits in the msb of the word
			for (int i = B - 1; i >= 0; i--) begin
				int1_next = int1_next + W'(fifoOutData[i]);
				int2_next = int2_next + int1_next;
				int3_next = int3_next + int2_next;
			end
			if (decCnt_reg >= cfg.osrWords) begin
				decCnt_next = sd_monitor_pkg::OSR_RESET;
				unique case (cfg.order)
					sd_monitor_pkg::SINC_ORDER1: x = int1_next;
					sd_monitor_pkg::SINC_ORDER2: x = int2_next;
					default:                     x = int3_next;
				endcase
				c1 = x - comb1_reg;
				c2 = c1 - comb2_reg;
				c3 = c2 - comb3_reg;
				comb1_next = x;
				comb2_next = c1;
				comb3_next = c2;
				sample_next.valid = 1'b1;
				unique case (cfg.order)
					sd_monitor_pkg::SINC_ORDER1: sample_next.data = c1;
					sd_monitor_pkg::SINC_ORDER2: sample_next.data = c2;
					default:                     sample_next.data = c3;
				endcase
			end else begin
				decCnt_next = decCnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			int1_reg   <= sd_monitor_pkg::ACC_RESET;
			int2_reg   <= sd_monitor_pkg::ACC_RESET;
			int3_reg   <= sd_monitor_pkg::ACC_RESET;
			comb1_reg  <= sd_monitor_pkg::ACC_RESET;
			comb2_reg  <= sd_monitor_pkg::ACC_RESET;
			comb3_reg  <= sd_monitor_pkg::ACC_RESET;
			decCnt_reg <= sd_monitor_pkg::OSR_RESET;
			sample_reg <= '0;
		end else begin
			int1_reg   <= int1_next;
			int2_reg   <= int2_next;
			int3_reg   <= int3_next;
			comb1_reg  <= comb1_next;
			comb2_reg  <= comb2_next;
			comb3_reg  <= comb3_next;
			decCnt_reg <= decCnt_next;
			sample_reg <= sample_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// limit checks, clock fail counter and sticky status

	logic                                     overHit;
	logic                                     underHit;
	logic                                     failHit;
	logic [sd_monitor_pkg::FAILCNT_WIDTH-1:0] failCnt_reg, failCnt_next;
	sd_monitor_pkg::monStatus_t               status_reg, status_next;

	// inclusive compares so high=0 / low=max trips on every sample
	assign overHit  = sample_reg.valid && (sample_reg.data >= cfg.highLimit);
	assign underHit = sample_reg.valid && (sample_reg.data <= cfg.lowLimit);
	assign failHit  = !modEdge && (failCnt_reg == sd_monitor_pkg::FAILCNT_LAST);

	always_comb begin
		status_next = status_reg;
		// saturating so a dead clock does not re-arm the counter
		if (modEdge) begin
			failCnt_next = sd_monitor_pkg::FAILCNT_RESET;
		end else if (failCnt_reg != sd_monitor_pkg::FAILCNT_LAST) begin
			failCnt_next = failCnt_reg + 1'b1;
		end else begin
			failCnt_next = failCnt_reg;
		end
		// set wins over a clear in the same cycle
		status_next.overValue  = overHit || (status_reg.overValue && !overClr);
		status_next.underValue = underHit || (status_reg.underValue && !underClr);
		status_next.clockFail  = failHit || (status_reg.clockFail && !clockFailClr);
		status_next.overrun    = (wordArrive && !fifoInReady) || (status_reg.overrun && !overrunClr);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			failCnt_reg <= sd_monitor_pkg::FAILCNT_RESET;
			status_reg  <= '0;
		end else begin
			failCnt_reg <= failCnt_next;
			status_reg  <= status_next;
		end
	end

	assign sample       = sample_reg;
	assign status       = status_reg;
	assign compIrq      = status_reg.overValue || status_reg.underValue;
	assign clockFailIrq = status_reg.clockFail;

endmodule

// ### testbench/bitstream_modulator.sv
// behavioural modulator model: gated bit clock and msb-first data words
`timescale 1ns/1ns
module bitstream_modulator (
	input  wire logic       run,
	input  wire logic [7:0] word,
	output logic            modClk,
	output logic            modData
);
	initial begin
		modClk = 1'b0;
		modData = 1'b0;
		#13;
		forever begin
			if (run) begin
				for (int i = 7; i >= 0; i--) begin
					modData = word[i];
					#40;
					modClk = 1'b1;
					#40;
					modClk = 1'b0;
				end
			end else begin
				// clock stands still; data wanders so a stale bit is never trusted
				modData = ~modData;
				#40;
			end
		end
	end
endmodule

// ### testbench/sd_unit_assertions.sv
// concurrent checks on the comparator filter and clock monitor ports
`timescale 1ns/1ns
module sd_unit_assertions (
	input wire logic                        clk,
	input wire logic                        nrst,
	input wire logic                        modClk,
	input wire sd_monitor_pkg::compCfg_t    cfg,
	input wire logic                        overClr,
	input wire sd_monitor_pkg::compSample_t sample,
	input wire sd_monitor_pkg::monStatus_t  status,
	input wire logic                        compIrq,
	input wire logic                        clockFailIrq
);
	logic       seen_reg;
	logic       seen_next;
	logic [9:0] idle_reg;
	logic [9:0] idle_next;

	// idle measured from any modClk change, so it leads the design's synchronised count
	always_comb begin
		seen_next = modClk;
		idle_next = (idle_reg == 10'h3FF) ? idle_reg : idle_reg + 10'h001;
		if (modClk != seen_reg) begin
			idle_next = 10'h000;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			seen_reg <= 1'b0;
			idle_reg <= 10'h000;
		end else begin
			seen_reg <= seen_next;
			idle_reg <= idle_next;
		end
	end

	////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	a_irq_follows_flags: assert property (compIrq == (status.overValue | status.underValue))
		else $error("limit irq differs from flags");
	a_fail_irq_tracks: assert property (clockFailIrq == status.clockFail)
		else $error("fail irq differs from flag");
	a_data_holds: assert property (!sample.valid |-> $stable(sample.data))
		else $error("filter output moved without valid");
	a_over_sets: assert property (sample.valid && sample.data >= cfg.highLimit |=> status.overValue)
		else $error("over flag missed");
	a_under_sets: assert property (sample.valid && sample.data <= cfg.lowLimit |=> status.underValue)
		else $error("under flag missed");
	a_over_cause: assert property ($rose(status.overValue) |-> $past(sample.valid) && $past(sample.data) >= $past(cfg.highLimit))
		else $error("over flag without cause");
	a_over_clear: assert property (overClr && !sample.valid |=> !status.overValue)
		else $error("over flag not cleared");
	a_fail_in_time: assert property (idle_reg == 10'h106 |-> status.clockFail)
		else $error("clock fail late");
	a_fail_not_early: assert property ($rose(status.clockFail) |-> idle_reg >= 10'h0FA)
		else $error("clock fail early");
endmodule

bind sigma_delta_filter_unit sd_unit_assertions checker_inst (.clk(clk), .nrst(nrst), .modClk(modClk), .cfg(cfg),
	.overClr(overClr), .sample(sample), .status(status), .compIrq(compIrq), .clockFailIrq(clockFailIrq));

// ### testbench/sigma_delta_filter_unit_test.sv
// self-checking bench for the comparator filter and clock monitor
`timescale 1ns/1ns
module sigma_delta_filter_unit_test;
	logic                        clk;
	logic                        nrst;
	logic                        modClk;
	logic                        modData;
	logic                        run;
	logic [7:0]                  modWord;
	sd_monitor_pkg::compCfg_t    cfg;
	logic                        overClr;
	logic                        underClr;
	logic                        failClr;
	logic                        overrunClr;
	sd_monitor_pkg::compSample_t sample;
	sd_monitor_pkg::monStatus_t  status;
	logic                        compIrq;
	logic                        clockFailIrq;
	int                          errors;
	int                          checks;
	int                          cycles;
	time                         lastEdge;

	bitstream_modulator modulator (.run(run), .word(modWord), .modClk(modClk), .modData(modData));
	sigma_delta_filter_unit dut (.clk(clk), .nrst(nrst), .modClk(modClk), .modData(modData), .cfg(cfg),
		.overClr(overClr), .underClr(underClr), .clockFailClr(failClr), .overrunClr(overrunClr),
		.sample(sample), .status(status), .compIrq(compIrq), .clockFailIrq(clockFailIrq));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// hang guard, well above the roughly 1500 cycles the tests take
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			$display("mismatch at %0t: timeout", $time);
			results();
		end
	end

	always @(posedge modClk) lastEdge = $time;

	////////////////////////////////////////
	task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s got %0h want %0h", $time, msg, got, exp);
		end
	endtask

	task waitValid;
		int n;
		n = 0;
		@(negedge clk);
		while (sample.valid !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		check({31'h0, sample.valid}, 32'h1, "sample valid");
	endtask

	task clearFlags;
		@(negedge clk);
		{overClr, underClr, failClr, overrunClr} = 4'hF;
		@(negedge clk);
		{overClr, underClr, failClr, overrunClr} = 4'h0;
	endtask

	task threshold_test;
		cfg = '{1'b1, sd_monitor_pkg::SINC_ORDER1, 5'h00, 32'h0000_0000, 32'hFFFF_FFFF};
		modWord = 8'h5A;
		for (int i = 0; i < 3; i++) begin
			clearFlags();
			waitValid();
			@(negedge clk);
			check({30'h0, status.overValue, status.underValue}, 32'h3, "both flags");
			check({31'h0, compIrq}, 32'h1, "limit irq");
		end
		$display("threshold test done");
	endtask

	task order_test;
		logic [31:0] exp;
		modWord = 8'hFF;
		for (int o = 0; o < 4; o++) begin
			// all-ones input over 32 bits gives gain 32 to the power of the order
			exp = (o == 1) ? 32'h20 : (o == 2) ? 32'h400 : 32'h8000;
			@(negedge clk);
			cfg = '{1'b0, sd_monitor_pkg::sincOrder_t'(o), 5'h03, o[0] ? exp : exp + 32'h1, o[0] ? exp - 32'h1 : exp};
			@(negedge clk);
			cfg.enable = 1'b1;
			repeat (4) waitValid();
			clearFlags();
			waitValid();
			check(sample.data, exp, "filter output");
			@(negedge clk);
			check({30'h0, status.overValue, status.underValue}, {30'h0, o[0], !o[0]}, "limit flags");
			check({31'h0, compIrq}, 32'h1, "limit irq");
		end
		$display("order test done");
	endtask

	task overrun_test;
		cfg.enable = 1'b0;
		repeat (320) @(negedge clk);
		check({31'h0, status.overrun}, 32'h1, "overrun on full fifo");
		cfg.enable = 1'b1;
		repeat (40) @(negedge clk);
		clearFlags();
		waitValid();
		check({31'h0, status.overrun}, 32'h0, "overrun after drain");
		$display("overrun test done");
	endtask

	task clockfail_test;
		int n;
		time gap;
		clearFlags();
		repeat (300) @(negedge clk);
		check({31'h0, clockFailIrq}, 32'h0, "no fail while running");
		run = 1'b0;
		n = 0;
		while (clockFailIrq !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		gap = ($time - lastEdge) / 100;
		check({31'h0, gap >= 256 && gap <= 261}, 32'h1, "fail delay");
		// a dead clock keeps the fail hit asserted, so the set beats the clear
		repeat (10) @(negedge clk);
		clearFlags();
		check({31'h0, clockFailIrq}, 32'h1, "fail holds while dead");
		run = 1'b1;
		repeat (10) @(negedge clk);
		clearFlags();
		check({31'h0, clockFailIrq}, 32'h0, "fail cleared");
		$display("clock fail test done");
	endtask

	task results;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		{errors, checks, cycles, lastEdge} = '0;
		{nrst, run, modWord} = '0;
		{overClr, underClr, failClr, overrunClr} = 4'h0;
		cfg = '0;
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		run = 1'b1;
		threshold_test();
		order_test();
		overrun_test();
		clockfail_test();
		results();
	end
endmodule
